// ### inc/odp_pkg.sv
// Purpose: shared constants of the output module parameter and diagnostic bank
// Assumes: eight output channels, one system clock
// Notes: record codes and byte positions are used by the bank; the bench repeats them as literals
package odp_pkg;
  // record codes seen by the coupler
  localparam logic [7:0] REC_PARAM = 8'h00;
  localparam logic [7:0] REC_DIAG_SHORT = 8'h00;
  localparam logic [7:0] REC_DIAG = 8'h01;
  localparam logic [7:0] REC_PARAM_READ = 8'h80;

  // byte counts of the records
  localparam logic [7:0] PARAM_BYTES = 8'h03;
  localparam logic [7:0] DIAG_SHORT_BYTES = 8'h04;
  localparam logic [7:0] DIAG_BYTES = 8'h14;

  // parameter record byte positions
  localparam logic [7:0] PB_DIAG_IRQ = 8'h00;
  localparam logic [7:0] PB_WIRE_BREAK = 8'h01;
  localparam logic [7:0] PB_SHORT_DET = 8'h02;

  // diagnostic record byte positions
  localparam logic [7:0] DB_ERR_A = 8'h00;
  localparam logic [7:0] DB_MOD_INFO = 8'h01;
  localparam logic [7:0] DB_RSVD = 8'h02;
  localparam logic [7:0] DB_ERR_D = 8'h03;
  localparam logic [7:0] DB_CH_TYPE = 8'h04;
  localparam logic [7:0] DB_BITS_PER_CH = 8'h05;
  localparam logic [7:0] DB_CH_COUNT = 8'h06;
  localparam logic [7:0] DB_CH_SUMMARY = 8'h07;
  localparam logic [7:0] DB_CH_FIRST = 8'h08;
  localparam logic [7:0] DB_TS_FIRST = 8'h10;

  // parameter values and resets
  localparam logic [7:0] DIAG_IRQ_OFF = 8'h00;
  localparam logic [7:0] DIAG_IRQ_ON = 8'h40;
  localparam logic [7:0] PARAM_RESET = 8'h00;
  localparam logic [7:0] MOD_INFO_VAL = 8'h1F;
  localparam logic [7:0] RSVD_VAL = 8'h00;
  localparam logic [7:0] CH_TYPE_VAL = 8'h72;
  localparam logic [7:0] BITS_PER_CH_VAL = 8'h08;
  localparam logic [7:0] CH_COUNT_VAL = 8'h08;

  // first module error byte bits
  localparam int EA_FAIL = 0;
  localparam int EA_INTERNAL = 1;
  localparam int EA_EXTERNAL = 2;
  localparam int EA_CHANNEL = 3;
  localparam int EA_AUX = 4;
  localparam int EA_PARAM = 7;
  // second module error byte bit
  localparam int ED_COMM = 4;
  // per-channel error byte bits
  localparam int CE_PARAM = 0;
  localparam int CE_SHORT_POS = 2;
  localparam int CE_SHORT_GND = 3;
  localparam int CE_WIRE_BREAK = 4;

  // fault vector layout after synchronising
  localparam int NUM_CH = 8;
  localparam int FV_SHORT_POS = 0;
  localparam int FV_SHORT_GND = 8;
  localparam int FV_WIRE_BREAK = 16;
  localparam int FV_AUX = 24;
  localparam int FV_COMM = 25;
  localparam int FLT_W = 26;

  // timer base
  localparam int US_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
endpackage : odp_pkg

// ### inc/odp_flt_if.sv
// Purpose: carries synchronised fault levels from the synchroniser to the bank
// Assumes: one clock domain on both ends
// Notes: plain level bus, no handshake
interface odp_flt_if #(
  parameter int W = odp_pkg::FLT_W
);
  logic [W-1:0] flt;
  modport src (output flt);
  modport dst (input flt);
endinterface : odp_flt_if

// ### logic/odp_sync.sv
// Purpose: three-stage synchroniser with agreement filter for fault pins
// Assumes: inputs are asynchronous levels from the field side
// Notes: output only follows when stages two and three agree
module odp_sync #(
  parameter int W = odp_pkg::FLT_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [W-1:0] raw_in,
  odp_flt_if.src flt_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } odp_sync_s;

  odp_sync_s q;
  odp_sync_s d;

  always_comb begin
    d = q;
    d.s1 = raw_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      // a one-sample glitch never reaches the bank
      if (q.s2[i] == q.s3[i]) begin
        d.stable[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign flt_out.flt = q.stable;
endmodule : odp_sync

// ### logic/odp_diag_regs.sv
// Purpose: parameter and diagnostic record bank of an eight-channel output module
// Assumes: coupler issues one record byte access per request, one clock
// Notes: error bytes mirror live conditions; timestamp holds the last new error
module odp_diag_regs #(
  parameter int CLK_PERIOD_NS = odp_pkg::CLK_PERIOD_NS
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic acc_req_in,
  input wire logic acc_write_in,
  input wire logic [7:0] acc_record_in,
  input wire logic [7:0] acc_index_in,
  input wire logic [7:0] acc_wdata_in,
  input wire logic [odp_pkg::NUM_CH-1:0] short_pos_in,
  input wire logic [odp_pkg::NUM_CH-1:0] short_gnd_in,
  input wire logic [odp_pkg::NUM_CH-1:0] wire_break_in,
  input wire logic aux_missing_in,
  input wire logic comm_error_in,
  output logic acc_ack_out,
  output logic acc_err_out,
  output logic [7:0] acc_rdata_out,
  output logic diag_event_out,
  output logic [odp_pkg::NUM_CH-1:0] chan_fault_out
);
  localparam int TICK_CYC = odp_pkg::US_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 16;

  if (CLK_PERIOD_NS < 1 || (odp_pkg::US_NS % CLK_PERIOD_NS) != 0 || TICK_CYC > 65535) begin : g_chk
    $error("clock period must divide one microsecond");
  end

  typedef struct packed {
    logic [7:0] diag_irq_enable;
    logic [7:0] wire_break_enable;
    logic [7:0] short_detect_enable;
    logic [7:0] module_error_flags;
    logic [7:0] module_error_flags_two;
    logic [7:0] channel_error_summary;
    logic [odp_pkg::NUM_CH-1:0][7:0] chan_error;
    logic [31:0] diag_timestamp;
    logic [31:0] us_timer;
    logic [DIV_W-1:0] div_cnt;
    logic [7:0] rdata;
    logic ack;
    logic err;
    logic event_p;
  } odp_state_s;

  odp_state_s q;
  odp_state_s d;
  odp_flt_if #(.W(odp_pkg::FLT_W)) flt_bus ();

  odp_sync #(
    .W(odp_pkg::FLT_W)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .raw_in({comm_error_in, aux_missing_in, wire_break_in, short_gnd_in, short_pos_in}),
    .flt_out(flt_bus)
  );

  // byte idx of the full diagnostic record
  function automatic logic [7:0] diag_byte(input logic [7:0] idx, input odp_state_s s);
    logic [7:0] r;
    logic [7:0] rel;
    r = odp_pkg::RSVD_VAL;
    rel = 8'h00;
    if (idx == odp_pkg::DB_ERR_A) begin
      r = s.module_error_flags;
    end else if (idx == odp_pkg::DB_MOD_INFO) begin
      r = odp_pkg::MOD_INFO_VAL;
    end else if (idx == odp_pkg::DB_ERR_D) begin
      r = s.module_error_flags_two;
    end else if (idx == odp_pkg::DB_CH_TYPE) begin
      r = odp_pkg::CH_TYPE_VAL;
    end else if (idx == odp_pkg::DB_BITS_PER_CH) begin
      r = odp_pkg::BITS_PER_CH_VAL;
    end else if (idx == odp_pkg::DB_CH_COUNT) begin
      r = odp_pkg::CH_COUNT_VAL;
    end else if (idx == odp_pkg::DB_CH_SUMMARY) begin
      r = s.channel_error_summary;
    end else if (idx >= odp_pkg::DB_CH_FIRST && idx < odp_pkg::DB_TS_FIRST) begin
      rel = idx - odp_pkg::DB_CH_FIRST;
      r = s.chan_error[rel[2:0]];
    end else if (idx >= odp_pkg::DB_TS_FIRST && idx < odp_pkg::DIAG_BYTES) begin
      // timestamp little end first
      rel = idx - odp_pkg::DB_TS_FIRST;
      r = s.diag_timestamp[8*rel[1:0] +: 8];
    end
    return r;
  endfunction : diag_byte

  // parameter record byte at idx
  function automatic logic [7:0] param_byte(input logic [7:0] idx, input odp_state_s s);
    logic [7:0] r;
    r = 8'h00;
    if (idx == odp_pkg::PB_DIAG_IRQ) begin
      r = s.diag_irq_enable;
    end else if (idx == odp_pkg::PB_WIRE_BREAK) begin
      r = s.wire_break_enable;
    end else if (idx == odp_pkg::PB_SHORT_DET) begin
      r = s.short_detect_enable;
    end
    return r;
  endfunction : param_byte

  logic [odp_pkg::NUM_CH-1:0] sp;
  logic [odp_pkg::NUM_CH-1:0] sg;
  logic [odp_pkg::NUM_CH-1:0] wb;
  logic aux;
  logic comm;

  assign sp = flt_bus.flt[odp_pkg::FV_SHORT_POS +: odp_pkg::NUM_CH];
  assign sg = flt_bus.flt[odp_pkg::FV_SHORT_GND +: odp_pkg::NUM_CH];
  assign wb = flt_bus.flt[odp_pkg::FV_WIRE_BREAK +: odp_pkg::NUM_CH];
  assign aux = flt_bus.flt[odp_pkg::FV_AUX];
  assign comm = flt_bus.flt[odp_pkg::FV_COMM];

  always_comb begin
    logic perr;
    logic any_ch;
    logic new_err;
    d = q;
    perr = 1'b0;
    any_ch = 1'b0;
    new_err = 1'b0;
    d.ack = 1'b0;
    d.err = 1'b0;
    d.event_p = 1'b0;

    // microsecond base from the system clock
    if (q.div_cnt == DIV_W'(TICK_CYC - 1)) begin
      d.div_cnt = '0;
      d.us_timer = q.us_timer + 32'h1;
    end else begin
      d.div_cnt = q.div_cnt + DIV_W'(1);
    end

    // only the two documented codes are legal
    perr = (q.diag_irq_enable != odp_pkg::DIAG_IRQ_OFF) &&
           (q.diag_irq_enable != odp_pkg::DIAG_IRQ_ON);

    for (int i = 0; i < odp_pkg::NUM_CH; i++) begin
      d.chan_error[i] = 8'h00;
      d.chan_error[i][odp_pkg::CE_PARAM] = perr;
      d.chan_error[i][odp_pkg::CE_SHORT_POS] = q.short_detect_enable[i] & sp[i];
      d.chan_error[i][odp_pkg::CE_SHORT_GND] = q.short_detect_enable[i] & sg[i];
      d.chan_error[i][odp_pkg::CE_WIRE_BREAK] = q.wire_break_enable[i] & wb[i];
      d.channel_error_summary[i] = |d.chan_error[i];
      new_err = new_err | (|(d.chan_error[i] & ~q.chan_error[i]));
    end
    any_ch = |d.channel_error_summary;

    d.module_error_flags = 8'h00;
    d.module_error_flags[odp_pkg::EA_INTERNAL] = comm;
    d.module_error_flags[odp_pkg::EA_EXTERNAL] = any_ch | aux;
    d.module_error_flags[odp_pkg::EA_CHANNEL] = any_ch;
    d.module_error_flags[odp_pkg::EA_AUX] = aux;
    d.module_error_flags[odp_pkg::EA_PARAM] = perr;
    d.module_error_flags[odp_pkg::EA_FAIL] = comm | any_ch | aux | perr;
    d.module_error_flags_two = 8'h00;
    d.module_error_flags_two[odp_pkg::ED_COMM] = comm;

    new_err = new_err |
              (|(d.module_error_flags & ~q.module_error_flags)) |
              (|(d.module_error_flags_two & ~q.module_error_flags_two));

    // stamp taken on every fresh error, even with reporting off
    if (new_err) begin
      d.diag_timestamp = q.us_timer;
    end
    if (new_err && q.diag_irq_enable == odp_pkg::DIAG_IRQ_ON) begin
      d.event_p = 1'b1;
    end

    if (acc_req_in) begin
      d.ack = 1'b1;
      if (acc_write_in) begin
        // no stop-state check here, the coupler guards it
        if (acc_record_in == odp_pkg::REC_PARAM && acc_index_in < odp_pkg::PARAM_BYTES) begin
          if (acc_index_in == odp_pkg::PB_DIAG_IRQ) begin
            d.diag_irq_enable = acc_wdata_in;
          end else if (acc_index_in == odp_pkg::PB_WIRE_BREAK) begin
            d.wire_break_enable = acc_wdata_in;
          end else begin
            d.short_detect_enable = acc_wdata_in;
          end
        end else begin
          d.err = 1'b1;
        end
      end else if (acc_record_in == odp_pkg::REC_DIAG && acc_index_in < odp_pkg::DIAG_BYTES) begin
        d.rdata = diag_byte(acc_index_in, q);
      end else if (acc_record_in == odp_pkg::REC_DIAG_SHORT &&
                   acc_index_in < odp_pkg::DIAG_SHORT_BYTES) begin
        d.rdata = diag_byte(acc_index_in, q);
      end else if (acc_record_in == odp_pkg::REC_PARAM_READ &&
                   acc_index_in < odp_pkg::PARAM_BYTES) begin
        d.rdata = param_byte(acc_index_in, q);
      end else begin
        d.rdata = 8'h00;
        d.err = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
      q.diag_irq_enable <= odp_pkg::PARAM_RESET;
      q.wire_break_enable <= odp_pkg::PARAM_RESET;
      q.short_detect_enable <= odp_pkg::PARAM_RESET;
    end else begin
      q <= d;
    end
  end

  assign acc_ack_out = q.ack;
  assign acc_err_out = q.err;
  assign acc_rdata_out = q.rdata;
  assign diag_event_out = q.event_p;
  assign chan_fault_out = q.channel_error_summary;
endmodule : odp_diag_regs

// ### test/odp_diag_regs_asserts.sv
// Purpose: port checker for the diagnostic record bank
// Assumes: one clock, asynchronous active-low reset
// Notes: answer latency of one cycle as handed over
module odp_diag_regs_asserts (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic acc_req_in,
  input wire logic acc_write_in,
  input wire logic [7:0] acc_record_in,
  input wire logic [7:0] acc_index_in,
  input wire logic acc_ack_out,
  input wire logic acc_err_out,
  input wire logic [7:0] acc_rdata_out,
  input wire logic diag_event_out,
  input wire logic [7:0] chan_fault_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  wire logic rd_diag = acc_req_in && !acc_write_in && acc_record_in == 8'h01;
  AST_ACK_ONE: assert property (acc_req_in |=> acc_ack_out)
    else $error("access not answered");
  AST_ACK_ONLY: assert property (!acc_req_in |=> !acc_ack_out && !acc_err_out)
    else $error("answer without access");
  AST_WR_REFUSE: assert property (acc_req_in && acc_write_in && acc_record_in != 8'h00
    |=> acc_err_out)
    else $error("write outside parameter record taken");
  AST_INFO: assert property (rd_diag && acc_index_in == 8'h01
    |=> acc_rdata_out == 8'h1F && !acc_err_out)
    else $error("module info wrong");
  AST_TYPE: assert property (rd_diag && acc_index_in == 8'h04 |=> acc_rdata_out == 8'h72)
    else $error("channel type wrong");
  AST_COUNTS: assert property (rd_diag && acc_index_in inside {8'h05, 8'h06}
    |=> acc_rdata_out == 8'h08)
    else $error("channel counts wrong");
  AST_RSVD: assert property (rd_diag && acc_index_in == 8'h02 |=> acc_rdata_out == 8'h00)
    else $error("reserved byte not zero");
  AST_SUMMARY: assert property (rd_diag && acc_index_in == 8'h07
    |=> acc_rdata_out == $past(chan_fault_out))
    else $error("summary differs from fault outputs");
  AST_EVT_PULSE: assert property (diag_event_out |=> !diag_event_out)
    else $error("event longer than one cycle");
  cover property (diag_event_out);
  cover property (acc_ack_out && acc_err_out);
  cover property (chan_fault_out != 8'h00);
endmodule : odp_diag_regs_asserts

bind odp_diag_regs odp_diag_regs_asserts odp_diag_regs_asserts_i (.sys_clk_in, .rst_b_in,
  .acc_req_in, .acc_write_in, .acc_record_in, .acc_index_in, .acc_ack_out, .acc_err_out,
  .acc_rdata_out, .diag_event_out, .chan_fault_out);

// ### test/odp_coupler_model.sv
// Purpose: backplane coupler model issuing record byte accesses
// Assumes: answer is registered on the taking edge and read at the next falling edge
// Notes: released lines show inverted values so stale data is never mistaken
module odp_coupler_model (
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic err_in,
  input wire logic [7:0] rdata_in,
  output logic req_out,
  output logic write_out,
  output logic [7:0] record_out,
  output logic [7:0] index_out,
  output logic [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_out = 1'b0;
    write_out = 1'b0;
    record_out = 8'h00;
    index_out = 8'h00;
    wdata_out = 8'h00;
  end
  // issues one record byte access, writes included, without any stop-state check
  task automatic acc(input logic w, input logic [7:0] rc, ix, wd,
                     output logic [7:0] rd, output logic er);
    @(negedge clk_in);
    req_out = 1'b1;
    write_out = w;
    record_out = rc;
    index_out = ix;
    wdata_out = wd;
    @(negedge clk_in);
    rd = rdata_in;
    er = err_in | ~ack_in;
    req_out = 1'b0;
    write_out = ~w;
    record_out = ~rc;
    index_out = ~ix;
    wdata_out = ~wd;
  endtask : acc
endmodule : odp_coupler_model

// ### test/test_odp_diag_regs.sv
// Purpose: self-checking bench of the diagnostic record bank
// Assumes: default timer divider, faults settle within eight cycles
// Notes: timer wrap is too long to reach here
module test_odp_diag_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in, rst_b_in, aux, comm, er;
  logic [7:0] s_pos, s_gnd, w_brk, rd;
  wire logic req, wr, ack, err, evt;
  wire logic [7:0] rec, idx, wd, rdata, fault;
  int n_mismatch, num_checks, cyc, ev_cyc, n_evt;
  odp_diag_regs odp_diag_regs_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .acc_req_in(req), .acc_write_in(wr), .acc_record_in(rec), .acc_index_in(idx),
    .acc_wdata_in(wd), .short_pos_in(s_pos), .short_gnd_in(s_gnd), .wire_break_in(w_brk),
    .aux_missing_in(aux), .comm_error_in(comm), .acc_ack_out(ack), .acc_err_out(err),
    .acc_rdata_out(rdata), .diag_event_out(evt), .chan_fault_out(fault));
  odp_coupler_model odp_coupler_model_i (.clk_in(sys_clk_in), .ack_in(ack), .err_in(err),
    .rdata_in(rdata), .req_out(req), .write_out(wr), .record_out(rec), .index_out(idx),
    .wdata_out(wd));
  always #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc <= rst_b_in ? cyc + 1 : 0;
    if (evt === 1'b1) begin
      n_evt <= n_evt + 1;
      ev_cyc <= cyc;
    end
    if (cyc > 20000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic rdx(input logic [7:0] rc, ix, e, input logic e_err = 1'b0);
    odp_coupler_model_i.acc(1'b0, rc, ix, 8'h00, rd, er);
    chk($sformatf("byte %0h.%0h", rc, ix), {e_err, e}, {er, rd});
  endtask : rdx
  task automatic wrx(input logic [7:0] rc, ix, v, input logic e_err = 1'b0);
    odp_coupler_model_i.acc(1'b1, rc, ix, v, rd, er);
    chk("write refusal", e_err, er);
  endtask : wrx
  task automatic settle();
    repeat (8) @(posedge sys_clk_in);
  endtask : settle
  task automatic t_consts();
    logic [7:0] tbl[8] = '{8'h00, 8'h1F, 8'h00, 8'h00, 8'h72, 8'h08, 8'h08, 8'h00};
    for (int i = 0; i < 8; i++) rdx(8'h01, i[7:0], tbl[i]);
    for (int i = 0; i < 4; i++) rdx(8'h00, i[7:0], tbl[i]);
    rdx(8'h00, 8'h04, 8'h00, 1'b1);
    rdx(8'h01, 8'h14, 8'h00, 1'b1);
  endtask : t_consts
  task automatic t_params();
    wrx(8'h00, 8'h00, 8'h40);
    wrx(8'h00, 8'h01, 8'hFF);
    wrx(8'h00, 8'h02, 8'hFF);
    wrx(8'h01, 8'h00, 8'h00, 1'b1);
    wrx(8'h00, 8'h03, 8'h00, 1'b1);
    rdx(8'h80, 8'h00, 8'h40);
    rdx(8'h80, 8'h01, 8'hFF);
    rdx(8'h80, 8'h02, 8'hFF);
  endtask : t_params
  task automatic t_short();
    logic [31:0] ts;
    @(negedge sys_clk_in);
    s_pos[0] = 1'b1;
    settle();
    chk("events", 1, n_evt);
    rdx(8'h01, 8'h08, 8'h04);
    rdx(8'h01, 8'h07, 8'h01);
    chk("fault out", 8'h01, fault);
    rdx(8'h01, 8'h00, 8'h0D);
    for (int i = 0; i < 4; i++) begin
      odp_coupler_model_i.acc(1'b0, 8'h01, 8'h10 + i[7:0], 8'h00, rd, er);
      chk("stamp refusal", 1'b0, er);
      ts[i*8 +: 8] = rd;
    end
    chk("stamp", 1'b1, int'(ts) <= ev_cyc / 100 && int'(ts) + 1 >= ev_cyc / 100);
    @(negedge sys_clk_in);
    s_pos[0] = 1'b0;
    s_gnd[3] = 1'b1;
    w_brk[7] = 1'b1;
    settle();
    rdx(8'h01, 8'h0B, 8'h08);
    rdx(8'h01, 8'h0F, 8'h10);
    rdx(8'h01, 8'h07, 8'h88);
    wrx(8'h00, 8'h01, 8'h7F);
    settle();
    rdx(8'h01, 8'h0F, 8'h00);
    wrx(8'h00, 8'h02, 8'hF7);
    settle();
    rdx(8'h01, 8'h07, 8'h00);
  endtask : t_short
  task automatic t_module();
    int ev0;
    @(negedge sys_clk_in);
    aux = 1'b1;
    comm = 1'b1;
    settle();
    rdx(8'h00, 8'h00, 8'h17);
    rdx(8'h00, 8'h03, 8'h10);
    wrx(8'h00, 8'h00, 8'h00);
    @(negedge sys_clk_in);
    aux = 1'b0;
    comm = 1'b0;
    settle();
    ev0 = n_evt;
    @(negedge sys_clk_in);
    aux = 1'b1;
    settle();
    chk("silent events", ev0, n_evt);
    wrx(8'h00, 8'h00, 8'h01);
    settle();
    rdx(8'h01, 8'h08, 8'h01);
    odp_coupler_model_i.acc(1'b0, 8'h01, 8'h00, 8'h00, rd, er);
    chk("param flag", 8'h80, rd & 8'h80);
  endtask : t_module
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    {sys_clk_in, rst_b_in, aux, comm, s_pos, s_gnd, w_brk} = '0;
    {n_mismatch, num_checks, n_evt, ev_cyc} = '0;
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    t_consts();
    t_params();
    t_short();
    t_module();
    results();
  end
endmodule : test_odp_diag_regs
